// >>> pkg/acs_defs.vh
/*
 * constants for the conversion sequencer: apb offsets, register fields,
 * reset values, mode and clock encodings and fixed counts.
 * assumes plain verilog-2005 and inclusion by bare name.
 */
// Function
// R01: converter off in reset or channel all ones
// R02: idle when done; async clock enabled at start
// R03: 12-bit approximation, 9-bit in 8-bit mode
// R04: round to 10 or 8 bits, place result
// R05: transfer sets complete flag, irq if enabled
// R06: compare result when compare enable set
// R07: four clock sources, bus clock after reset
// R08: divide selected clock by 1, 2, 4, 8
// R09: async clock kept running in wait, stop3
// R10: disabled pin: hi-z, no input, no pullup
// R11: upper disable bits 7..0 map channels 23..16
// R12: hardware trigger rising edge starts conversion
// R13: ignore edges while busy or continuous running
// R14: first control write starts unless channel ones
// R15: continuous mode restarts after every transfer
// R16: high read without low read blocks transfer; code blocks only outside 8-bit mode
// R17: blocked transfer restarts, except failed single compare
// R18: software avoids result reads during single conversion
// R19: control, config, compare writes abort conversion
// R20: reset or stop without async clock aborts
// R21: abort keeps result; reset clears it
// R22: low power bit lowers converter power
// R23: clock select codes 00 bus to 11 async
// R24: mode codes 00 8-bit, 01 12, 10 10-bit
// R25: compare gates flag and transfer by direction
// R26: synchronise hardware trigger before edge detect
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH

// register byte offsets on apb
`define ACS_OFF_SC1     12'h000
`define ACS_OFF_SC2     12'h004
`define ACS_OFF_RESH    12'h008
`define ACS_OFF_RESL    12'h00C
`define ACS_OFF_CVH     12'h010
`define ACS_OFF_CVL     12'h014
`define ACS_OFF_CFG     12'h018
`define ACS_OFF_PDL     12'h01C
`define ACS_OFF_PDM     12'h020
`define ACS_OFF_PDU     12'h024
`define ACS_OFF_MODE    12'h028

// first status/control fields
`define ACS_SC1_CONVERSION_COMPLETE_FLAG    7
`define ACS_SC1_COMPLETE_IRQ_ENABLE    6
`define ACS_SC1_CONT    5
`define ACS_CH_OFF      5'h1F
// second status/control fields
`define ACS_SC2_ACT     7
`define ACS_SC2_TRG     6
`define ACS_SC2_CFE     5
`define ACS_SC2_CFGT    4
// configuration fields
`define ACS_CFG_LPC     7
`define ACS_CFG_DIVH    6
`define ACS_CFG_DIVL    5
`define ACS_CFG_MODEH   3
`define ACS_CFG_MODEL   2
// system mode register fields
`define ACS_MD_WAIT     0
`define ACS_MD_STOP     1

// resolution and clock source codes
`define ACS_MODE_8      2'h0
`define ACS_MODE_12     2'h1
`define ACS_MODE_10     2'h2
`define ACS_CLK_BUS     2'h0
`define ACS_CLK_BUS2    2'h1
`define ACS_CLK_ALT     2'h2
`define ACS_CLK_ASYNC   2'h3

// reset values
`define ACS_SC1_RST     8'h1F
`define ACS_ZERO8       8'h00
// converter clock ticks per conversion (sample plus approximation)
`define ACS_CONV_TICKS  5'h17
`define ACS_TICK_ONE    5'h01

`endif

// >>> verilog/acs_adc_conversion_sequencer.v
/*
 * control logic of a successive-approximation converter: apb register
 * file, clock source and divider, trigger handling, rounding, compare,
 * result blocking and abort. assumes an analogue core that converts on
 * request and returns a 12-bit raw code; async and alternate clocks
 * arrive as pins and are only sampled as tick sources here.
 */
`timescale 1ns/10ps
`include "acs_defs.vh"

module acs_adc_conversion_sequencer (
	input  wire        clk,            // bus clock, 50 MHz
	input  wire        reset,          // synchronous, active high
	input  wire        psel,           // apb select
	input  wire        penable,        // apb access phase
	input  wire        pwrite,         // apb direction
	input  wire [11:0] paddr,          // apb byte address
	input  wire [31:0] pwdata,         // apb write data
	output reg  [31:0] prdata,         // apb read data
	output reg         pready,         // apb ready
	output reg         pslverr,        // apb error
	input  wire        hwTrigger,      // asynchronous hardware trigger
	input  wire        altClock,       // alternate clock source pin
	input  wire        asyncClock,     // internal async oscillator output
	input  wire [11:0] coreResult,     // raw approximation code from core
	output reg         coreStart,      // start pulse to analogue core
	output reg         coreEnable,     // core powered
	output reg         asyncClockEn,   // async oscillator enable
	output reg         lowPower,       // low power bias to core
	output reg         convClock,      // converter clock level
	output reg  [4:0]  coreChannel,    // channel to core
	output reg  [23:0] pinDisable,     // per-pin analogue disable
	output reg         completeIrq     // completion interrupt level
);

	// state codes
	localparam ST_IDLE = 2'h0;             // waiting for a start
	localparam ST_CONV = 2'h1;             // conversion running
	localparam ST_DONE = 2'h2;             // result evaluation

	// software visible registers
	reg  [7:0]  sc1_ff;                    // flag, irq enable, continuous, channel
	reg  [7:0]  sc2_ff;                    // trigger, compare controls
	reg  [7:0]  cfg_ff;                    // low power, divide, mode, clock
	reg  [7:0]  cvh_ff;                    // compare value high
	reg  [7:0]  cvl_ff;                    // compare value low
	reg  [7:0]  resh_ff;                   // result high
	reg  [7:0]  resl_ff;                   // result low
	reg  [1:0]  sysMode_ff;                // wait and stop indications
	reg  [1:0]  state_ff;                  // sequencer state
	reg  [4:0]  ticks_ff;                  // converter clock ticks left
	reg  [2:0]  div_ff;                    // converter clock divider
	reg         halfBus_ff;                // bus clock halved
	reg         highRead_ff;               // high read, low not yet
	reg         contRun_ff;                // continuous sequence active
	reg  [2:0]  trgSync_ff;                // trigger synchroniser + history
	reg  [1:0]  altSync_ff;                // alternate clock synchroniser
	reg  [1:0]  asySync_ff;                // async clock synchroniser
	reg         altLast_ff;                // previous alternate level
	reg         asyLast_ff;                // previous async level

	// decoded bus access
	wire        wrEn   = psel & penable & pwrite;
	wire        rdEn   = psel & penable & ~pwrite;
	wire        wrSc1  = wrEn & (paddr == `ACS_OFF_SC1);
	wire        wrCfgs = wrEn & ((paddr == `ACS_OFF_SC2) | (paddr == `ACS_OFF_CFG) |
		(paddr == `ACS_OFF_CVH) | (paddr == `ACS_OFF_CVL));
	wire        rdResh = rdEn & (paddr == `ACS_OFF_RESH);
	wire        rdResl = rdEn & (paddr == `ACS_OFF_RESL);
	wire        chanOff = (sc1_ff[4:0] == `ACS_CH_OFF);
	wire [1:0]  mode   = cfg_ff[`ACS_CFG_MODEH:`ACS_CFG_MODEL];
	wire [1:0]  clkSel = cfg_ff[1:0];
	wire [1:0]  divSel = cfg_ff[`ACS_CFG_DIVH:`ACS_CFG_DIVL];
	wire        isAsync = (clkSel == `ACS_CLK_ASYNC);
	wire        stopAbort = sysMode_ff[`ACS_MD_STOP] & ~isAsync; // R20
	wire        hwMode = sc2_ff[`ACS_SC2_TRG];
	wire        cfe    = sc2_ff[`ACS_SC2_CFE];
	wire        cfgt   = sc2_ff[`ACS_SC2_CFGT];
	wire        contEn = sc1_ff[`ACS_SC1_CONT];
	wire        trgRise = trgSync_ff[1] & ~trgSync_ff[2]; // R26

	// source tick selection, one pulse per source clock period
	reg         srcTick;
	always @* begin
		case (clkSel) // R07 R23
			`ACS_CLK_BUS:  srcTick = 1'b1;
			`ACS_CLK_BUS2: srcTick = halfBus_ff;
			`ACS_CLK_ALT:  srcTick = altSync_ff[1] & ~altLast_ff;
			default:       srcTick = asySync_ff[1] & ~asyLast_ff;
		endcase
	end

	// divider: 1, 2, 4 or 8 source ticks per converter tick
	wire [2:0]  divMax = (3'h1 << divSel) - 3'h1;
	wire        convTick = srcTick & (div_ff >= divMax); // R08

	// rounding and compare arithmetic
	wire [12:0] rnd10  = {1'b0, coreResult} + 13'h0002;
	wire [12:0] rnd8   = {1'b0, coreResult} + 13'h0008;
	reg  [11:0] rounded;                   // result at selected width
	always @* begin
		case (mode) // R03 R04 R24
			`ACS_MODE_10: rounded = rnd10[12] ? 12'h3FF : {2'h0, rnd10[11:2]};
			`ACS_MODE_8:  rounded = rnd8[12] ? 12'h0FF : {4'h0, rnd8[11:4]};
			default:      rounded = coreResult;
		endcase
	end
	wire [11:0] cmpVal = {cvh_ff[3:0], cvl_ff};
	wire [11:0] diff   = rounded - cmpVal; // two's complement add
	wire        geq    = (rounded >= cmpVal);
	wire        cmpOk  = ~cfe | (cfgt ? geq : ~geq); // R06 R25
	wire [11:0] xfer   = cfe ? diff : rounded;
	wire        blocked = highRead_ff & (mode != `ACS_MODE_8); // R16

	// start requests
	wire        wrChanOk = wrSc1 & (pwdata[4:0] != `ACS_CH_OFF);
	wire        hwStart = hwMode & trgRise & (state_ff == ST_IDLE) & ~contRun_ff &
		~chanOff; // R12 R13

	// sequencer
	reg  [1:0]  nxt_state;
	reg         nxt_start;
	reg         nxt_xfer;
	reg         nxt_cont;
	always @* begin
		nxt_state = state_ff;
		nxt_start = 1'b0;
		nxt_xfer  = 1'b0;
		nxt_cont  = contRun_ff;
		if (wrSc1 | wrCfgs | stopAbort | chanOff) begin // R19 R20 R01
			nxt_state = ST_IDLE;
			nxt_cont  = 1'b0;
			if (wrChanOk & ~hwMode) begin // R14
				nxt_state = ST_CONV;
				nxt_start = 1'b1;
				nxt_cont  = pwdata[`ACS_SC1_CONT];
			end
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (hwStart) begin
						nxt_state = ST_CONV;
						nxt_start = 1'b1;
						nxt_cont  = contEn;
					end
				end
				ST_CONV: begin
					if (convTick & (ticks_ff == `ACS_TICK_ONE))
						nxt_state = ST_DONE;
				end
				ST_DONE: begin
					nxt_xfer = cmpOk & ~blocked; // R05
					if (blocked & ~(~contEn & cfe & ~cmpOk)) begin // R17
						nxt_state = ST_CONV;
						nxt_start = 1'b1;
					end else if (contEn) begin // R15
						nxt_state = ST_CONV;
						nxt_start = 1'b1;
					end else begin
						nxt_state = ST_IDLE; // R02
						nxt_cont  = 1'b0;
					end
				end
				default: nxt_state = ST_IDLE;
			endcase
		end
	end

	// registers, sequencing and clocking
	always @(posedge clk) begin
		if (reset) begin // R01 R21
			sc1_ff      <= `ACS_SC1_RST;
			sc2_ff      <= `ACS_ZERO8;
			cfg_ff      <= `ACS_ZERO8;
			cvh_ff      <= `ACS_ZERO8;
			cvl_ff      <= `ACS_ZERO8;
			resh_ff     <= `ACS_ZERO8;
			resl_ff     <= `ACS_ZERO8;
			sysMode_ff  <= 2'h0;
			pinDisable  <= 24'h000000;
			state_ff    <= ST_IDLE;
			ticks_ff    <= 5'h00;
			div_ff      <= 3'h0;
			halfBus_ff  <= 1'b0;
			highRead_ff <= 1'b0;
			contRun_ff  <= 1'b0;
			trgSync_ff  <= 3'h0;
			altSync_ff  <= 2'h0;
			asySync_ff  <= 2'h0;
			altLast_ff  <= 1'b0;
			asyLast_ff  <= 1'b0;
			prdata      <= 32'h00000000;
			pready      <= 1'b0;
			pslverr     <= 1'b0;
			coreStart   <= 1'b0;
			coreEnable  <= 1'b0;
			asyncClockEn <= 1'b0;
			lowPower    <= 1'b0;
			convClock   <= 1'b0;
			coreChannel <= 5'h1F;
			completeIrq <= 1'b0;
		end else begin
			// pin inputs: two flops before any use
			trgSync_ff <= {trgSync_ff[1:0], hwTrigger};
			altSync_ff <= {altSync_ff[0], altClock};
			asySync_ff <= {asySync_ff[0], asyncClock};
			altLast_ff <= altSync_ff[1];
			asyLast_ff <= asySync_ff[1];
			halfBus_ff <= ~halfBus_ff;
			state_ff   <= nxt_state;
			contRun_ff <= nxt_cont;
			coreStart  <= nxt_start;

			// divider runs continuously, cleared at each start
			if (nxt_start)
				div_ff <= 3'h0;
			else if (srcTick)
				div_ff <= convTick ? 3'h0 : div_ff + 3'h1;
			if (nxt_start)
				ticks_ff <= `ACS_CONV_TICKS;
			else if (convTick & (state_ff == ST_CONV))
				ticks_ff <= ticks_ff - 5'h01;
			if (convTick & (state_ff == ST_CONV))
				convClock <= ~convClock;

			// result transfer keeps old data on abort
			if (nxt_xfer) begin // R04 R21
				resh_ff <= {4'h0, xfer[11:8]};
				resl_ff <= xfer[7:0];
			end

			// high-then-low read tracking for blocking
			if (rdResh)
				highRead_ff <= 1'b1; // R16
			else if (rdResl | wrSc1)
				highRead_ff <= 1'b0;

			// completion flag: set wins, cleared by control write or low result read
			if (nxt_xfer)
				sc1_ff[`ACS_SC1_CONVERSION_COMPLETE_FLAG] <= 1'b1; // R05
			else if (wrSc1 | rdResl)
				sc1_ff[`ACS_SC1_CONVERSION_COMPLETE_FLAG] <= 1'b0;
			if (wrSc1)
				sc1_ff[6:0] <= pwdata[6:0];

			// configuration writes
			if (wrEn & (paddr == `ACS_OFF_SC2))
				sc2_ff <= {1'b0, pwdata[6:4], 4'h0};
			if (wrEn & (paddr == `ACS_OFF_CFG))
				cfg_ff <= {pwdata[7:5], 1'b0, pwdata[3:0]};
			if (wrEn & (paddr == `ACS_OFF_CVH))
				cvh_ff <= {4'h0, pwdata[3:0]};
			if (wrEn & (paddr == `ACS_OFF_CVL))
				cvl_ff <= pwdata[7:0];
			if (wrEn & (paddr == `ACS_OFF_MODE))
				sysMode_ff <= pwdata[1:0];
			if (wrEn & (paddr == `ACS_OFF_PDL))
				pinDisable[7:0] <= pwdata[7:0]; // R10
			if (wrEn & (paddr == `ACS_OFF_PDM))
				pinDisable[15:8] <= pwdata[7:0];
			if (wrEn & (paddr == `ACS_OFF_PDU))
				pinDisable[23:16] <= pwdata[7:0]; // R11

			// outputs to the analogue core
			coreEnable   <= (nxt_state != ST_IDLE); // R02
			asyncClockEn <= isAsync & ((nxt_state != ST_IDLE) |
				sysMode_ff[`ACS_MD_WAIT] | sysMode_ff[`ACS_MD_STOP]); // R02 R09
			// bias and channel follow a write at once, in step with coreEnable
			lowPower     <= (wrEn & (paddr == `ACS_OFF_CFG)) ? pwdata[`ACS_CFG_LPC] :
				cfg_ff[`ACS_CFG_LPC]; // R22
			coreChannel  <= wrSc1 ? pwdata[4:0] : sc1_ff[4:0];
			completeIrq  <= (sc1_ff[`ACS_SC1_CONVERSION_COMPLETE_FLAG] | nxt_xfer) & sc1_ff[`ACS_SC1_COMPLETE_IRQ_ENABLE] &
				~(wrSc1 & ~pwdata[`ACS_SC1_COMPLETE_IRQ_ENABLE]);

			// apb: zero wait states, unmapped reads zero with error
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
			if (psel & ~penable) begin
				case (paddr)
					`ACS_OFF_SC1:  prdata[7:0] <= sc1_ff;
					`ACS_OFF_SC2:  prdata[7:0] <= {(state_ff != ST_IDLE), sc2_ff[6:0]};
					`ACS_OFF_RESH: prdata[7:0] <= resh_ff;
					`ACS_OFF_RESL: prdata[7:0] <= resl_ff;
					`ACS_OFF_CVH:  prdata[7:0] <= cvh_ff;
					`ACS_OFF_CVL:  prdata[7:0] <= cvl_ff;
					`ACS_OFF_CFG:  prdata[7:0] <= cfg_ff;
					`ACS_OFF_PDL:  prdata[7:0] <= pinDisable[7:0];
					`ACS_OFF_PDM:  prdata[7:0] <= pinDisable[15:8];
					`ACS_OFF_PDU:  prdata[7:0] <= pinDisable[23:16];
					`ACS_OFF_MODE: prdata[7:0] <= {6'h00, sysMode_ff};
					default:       pslverr <= 1'b1;
				endcase
			end
		end
	end

endmodule

// >>> verification/acs_seq_monitor.sv
/* port checker for the conversion sequencer: start, abort, pins, power.
   assumes the apb offsets of acs_defs.vh and one bus clock domain. */
`timescale 1ns/10ps
`include "acs_defs.vh"
module acs_seq_monitor (
	input wire        clk,         // bus clock
	input wire        reset,       // sync reset
	input wire        psel,        // apb select
	input wire        penable,     // apb access
	input wire        pwrite,      // apb direction
	input wire [11:0] paddr,       // apb address
	input wire [31:0] pwdata,      // apb write data
	input wire        pready,      // apb ready
	input wire        hwTrigger,   // trigger pin
	input wire        coreStart,   // launch pulse
	input wire        coreEnable,  // converting
	input wire        lowPower,    // low power bias
	input wire [4:0]  coreChannel, // channel
	input wire [23:0] pinDisable   // pin disables
);
	logic trgSel_ff;                                     // shadow of trigger select
	wire  wrDone = psel && penable && pwrite && pready; // write lands here
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// shadow needed: a control write only starts in software mode
	always @(posedge clk) begin
		if (reset)
			trgSel_ff <= 1'b0;
		else if (wrDone && paddr == `ACS_OFF_SC2)
			trgSel_ff <= pwdata[`ACS_SC2_TRG];
	end
	chk_reset_off: assert property (disable iff (1'b0) reset |=> !coreEnable && coreChannel == 5'h1F)
		else $error("converter active after reset");
	chk_chan_off: assert property (coreChannel == `ACS_CH_OFF |-> !coreEnable)
		else $error("converter active with channel all ones");
	chk_pin_upper: assert property (wrDone && paddr == `ACS_OFF_PDU |=> pinDisable[23:16] == $past(pwdata[7:0]))
		else $error("upper pin disables wrong");
	chk_low_power: assert property (wrDone && paddr == `ACS_OFF_CFG |=> lowPower == $past(pwdata[7]))
		else $error("low power bias wrong");
	chk_abort_write: assert property (wrDone && paddr inside {`ACS_OFF_SC2, `ACS_OFF_CFG, `ACS_OFF_CVH, `ACS_OFF_CVL} |=> !coreEnable)
		else $error("conversion survived a mode write");
	chk_sw_start: assert property (wrDone && paddr == `ACS_OFF_SC1 && pwdata[4:0] != `ACS_CH_OFF && !trgSel_ff |-> ##[1:3] coreStart)
		else $error("software start missing");
	chk_start_run: assert property (coreStart |-> ##[0:2] coreEnable)
		else $error("launch without converter enabled");
	chk_hw_start: assert property ($rose(hwTrigger) && trgSel_ff && !coreEnable && coreChannel != `ACS_CH_OFF && !psel |-> !coreStart [*2] ##[1:4] coreStart)
		else $error("trigger edge start wrong");
	cov_start: cover property (coreStart);
	cov_pins: cover property (wrDone && paddr == `ACS_OFF_PDU);
	cov_trig: cover property ($rose(hwTrigger) && trgSel_ff);
endmodule
bind acs_adc_conversion_sequencer acs_seq_monitor acs_seq_monitor_i (.clk(clk), .reset(reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .hwTrigger(hwTrigger), .coreStart(coreStart), .coreEnable(coreEnable),
	.lowPower(lowPower), .coreChannel(coreChannel), .pinDisable(pinDisable));

// >>> verification/acs_core_model.sv
/* behavioural analogue core and clock pins for the sequencer.
   assumes the bench sets the code that the next launch converts. */
`timescale 1ns/10ps
module acs_core_model (
	input  wire         clk,          // bus clock
	input  wire         coreStart,    // launch pulse
	input  wire         asyncClockEn, // oscillator enable
	input  wire  [11:0] rawCode,      // code to convert
	output logic [11:0] coreResult,   // held code
	output logic        asyncClock,   // internal oscillator
	output logic        altClock      // alternate source
);
	initial begin
		coreResult = 12'h000;
		asyncClock = 1'b0;
		altClock = 1'b0;
	end
	// latch at launch, so a later code change cannot leak in
	always @(posedge clk) begin
		if (coreStart)
			coreResult <= rawCode;
	end
	// alternate source free-runs, unrelated in phase
	always #17 altClock = ~altClock;
	// oscillator stands still unless enabled
	always #7 asyncClock = asyncClockEn ? ~asyncClock : 1'b0;
endmodule

// >>> verification/acs_adc_conversion_sequencer_test.sv
/* bench for the sequencer: apb master, scenario tasks, verdict.
   assumes the core model beside it and a 50 MHz bus clock. */
`timescale 1ns/10ps
`include "acs_defs.vh"
module acs_adc_conversion_sequencer_test;
	logic        clk, reset, psel, penable, pwrite, hwTrigger, errSeen; // drives
	logic [11:0] paddr, rawCode;     // address, code to convert
	logic [31:0] pwdata, rd;         // write data, last read
	wire  [31:0] prdata;             // read data
	wire         pready, pslverr, altClock, asyncClock, coreStart, coreEnable;
	wire         asyncClockEn, lowPower, convClock, completeIrq; // core side
	wire  [11:0] coreResult;         // from core model
	wire  [4:0]  coreChannel;        // channel
	wire  [23:0] pinDisable;         // pin disables
	int          err_count, checks_done; // tallies
	acs_adc_conversion_sequencer acs_adc_conversion_sequencer_i (.clk(clk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .hwTrigger(hwTrigger),
		.altClock(altClock), .asyncClock(asyncClock), .coreResult(coreResult),
		.coreStart(coreStart), .coreEnable(coreEnable), .asyncClockEn(asyncClockEn),
		.lowPower(lowPower), .convClock(convClock), .coreChannel(coreChannel),
		.pinDisable(pinDisable), .completeIrq(completeIrq));
	acs_core_model acs_core_model_i (.clk(clk), .coreStart(coreStart), .rawCode(rawCode),
		.asyncClockEn(asyncClockEn), .coreResult(coreResult), .asyncClock(asyncClock),
		.altClock(altClock));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// one transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk("pready", 32'h1, pready);
		rd = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic waitFlag;
		int n = 0;
		do begin
			apb(1'h0, `ACS_OFF_SC1, 32'h0);
			n++;
		end while (rd[7] !== 1'b1 && n < 100);
		chk("flag", 32'h1, rd[7]);
	endtask
	task automatic t_reset;
		apb(1'h0, `ACS_OFF_SC1, 32'h0);
		chk("sc1", 32'h1F, rd);
		apb(1'h0, `ACS_OFF_CFG, 32'h0);
		chk("cfg", 32'h0, rd);
		chk("enable", 32'h0, coreEnable);
		chk("asyncen", 32'h0, asyncClockEn);
		chk("convclk", 32'h0, convClock);
	endtask
	task automatic t_pins;
		apb(1'h1, `ACS_OFF_PDU, 32'hA5);
		apb(1'h0, `ACS_OFF_PDU, 32'h0);
		chk("pdu", 32'hA5, rd);
		chk("pins", 32'hA50000, {8'h00, pinDisable});
		apb(1'h0, 12'h0FC, 32'h0);
		chk("slverr", 32'h1, errSeen);
	endtask
	// every mode, rounding of one code, lowPower set in the last pass
	task automatic t_modes;
		logic [1:0]  mode [3] = '{`ACS_MODE_12, `ACS_MODE_10, `ACS_MODE_8};
		logic [31:0] hi [3] = '{32'h7, 32'h1, 32'h0};
		logic [31:0] lo [3] = '{32'hFA, 32'hFF, 32'h80};
		rawCode <= 12'h7FA;
		for (int i = 0; i < 3; i++) begin
			apb(1'h1, `ACS_OFF_CFG, {24'h0, i == 2, 3'h0, mode[i], 2'h0});
			@(negedge clk);
			chk("lowpower", i == 2, lowPower);
			apb(1'h1, `ACS_OFF_SC1, 32'h43);
			waitFlag();
			chk("irq", 32'h1, completeIrq);
			apb(1'h0, `ACS_OFF_RESH, 32'h0);
			chk("resh", hi[i], rd);
			apb(1'h0, `ACS_OFF_RESL, 32'h0);
			chk("resl", lo[i], rd);
		end
	endtask
	// hardware start, then an abort that must keep the old result
	task automatic t_hwtrig;
		apb(1'h1, `ACS_OFF_SC2, 32'h40);
		apb(1'h1, `ACS_OFF_SC1, 32'h05);
		repeat (60) @(posedge clk);
		chk("nostart", 32'h0, coreEnable);
		rawCode <= 12'h123;
		hwTrigger <= 1'b1;
		waitFlag();
		chk("irqoff", 32'h0, completeIrq);
		apb(1'h0, `ACS_OFF_RESL, 32'h0);
		chk("hwresl", 32'h12, rd);
		hwTrigger <= 1'b0;
		rawCode <= 12'h456;
		apb(1'h1, `ACS_OFF_SC2, 32'h0);
		apb(1'h1, `ACS_OFF_SC1, 32'h05);
		apb(1'h1, `ACS_OFF_CVL, 32'h0);
		repeat (60) @(posedge clk);
		apb(1'h0, `ACS_OFF_SC1, 32'h0);
		chk("aborted", 32'h05, rd);
		apb(1'h0, `ACS_OFF_RESL, 32'h0);
		chk("kept", 32'h12, rd);
	endtask
	// compare pass then fail; divide by 8 stretches the conversion
	task automatic t_compare;
		rawCode <= 12'h7FA;
		apb(1'h1, `ACS_OFF_CFG, 32'h64);
		apb(1'h1, `ACS_OFF_CVH, 32'h7);
		apb(1'h1, `ACS_OFF_CVL, 32'h0);
		apb(1'h1, `ACS_OFF_SC2, 32'h30);
		apb(1'h1, `ACS_OFF_SC1, 32'h03);
		repeat (100) @(posedge clk);
		apb(1'h0, `ACS_OFF_SC1, 32'h0);
		chk("slowflag", 32'h0, rd[7]);
		waitFlag();
		apb(1'h0, `ACS_OFF_RESL, 32'h0);
		chk("cmpresl", 32'hFA, rd);
		apb(1'h1, `ACS_OFF_CVL, 32'hFB);
		apb(1'h1, `ACS_OFF_SC1, 32'h03);
		repeat (220) @(posedge clk);
		apb(1'h0, `ACS_OFF_SC1, 32'h0);
		chk("cmpfail", 32'h03, rd);
		chk("cmpidle", 32'h0, coreEnable);
		apb(1'h0, `ACS_OFF_RESL, 32'h0);
		chk("cmpkept", 32'hFA, rd);
	endtask
	// high read mid-conversion blocks transfers; then continuous mode
	task automatic t_block;
		apb(1'h1, `ACS_OFF_SC2, 32'h0);
		apb(1'h1, `ACS_OFF_CFG, 32'h04);
		rawCode <= 12'h321;
		apb(1'h1, `ACS_OFF_SC1, 32'h03);
		apb(1'h0, `ACS_OFF_RESH, 32'h0);
		repeat (80) @(posedge clk);
		apb(1'h0, `ACS_OFF_SC1, 32'h0);
		chk("blkflag", 32'h03, rd);
		chk("blkrun", 32'h1, coreEnable);
		apb(1'h0, `ACS_OFF_RESL, 32'h0);
		waitFlag();
		apb(1'h0, `ACS_OFF_RESH, 32'h0);
		chk("blkresh", 32'h3, rd);
		apb(1'h0, `ACS_OFF_RESL, 32'h0);
		chk("blkresl", 32'h21, rd);
		apb(1'h1, `ACS_OFF_SC1, 32'h23);
		waitFlag();
		apb(1'h0, `ACS_OFF_RESL, 32'h0);
		waitFlag();
		apb(1'h1, `ACS_OFF_SC1, 32'h1F);
		@(negedge clk);
		chk("stopped", 32'h0, coreEnable);
	endtask
	task report_and_stop;
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// watchdog: whole run needs far fewer than 20000 cycles
	initial begin
		#400000;
		err_count++;
		report_and_stop();
	end
	initial begin
		{reset, psel, penable, pwrite, hwTrigger} = 5'h10;
		paddr = 12'h000;
		pwdata = 32'h0;
		rawCode = 12'h000;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_pins();
		t_modes();
		t_hwtrig();
		t_compare();
		t_block();
		report_and_stop();
	end
endmodule
